// File: rtl/cse_server.sv
// Server end: periodic synchronize-clock request and reply parser
`timescale 1ns/1ps
module cse_server #(
   parameter int TIMEOUT_CYC    = cse_pkg::REPLY_TIMEOUT_CYC,
   parameter int TICKS_PER_UNIT = cse_pkg::TICKS_PER_UNIT
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_CE,
   input  wire logic        I_ENABLE,
   input  wire logic [15:0] I_SYNC_COUNT,
   input  wire logic [23:0] I_CLIENT_ID,
   input  wire logic [23:0] I_SERVER_ID,
   input  wire logic        I_USE_WKA,
   input  wire logic [31:0] I_PROP_DELAY,
   input  wire logic        I_TICK,
   input  wire logic        I_TX_BUSY,
   input  wire logic        I_TX_READY,
   input  wire logic        I_RX_VALID,
   input  wire logic [15:0] I_RX_OXID,
   input  wire logic        I_RX_REJECT,
   input  wire logic [31:0] I_RX_DATA,
   output logic             O_TX_VALID,
   output logic [31:0]      O_TX_DATA,
   output logic             O_TX_LAST,
   output logic [23:0]      O_TX_SID,
   output logic [23:0]      O_TX_DID,
   output logic [15:0]      O_TX_OXID,
   output logic             O_TX_SEQ_INIT,
   output logic             O_BUSY,
   output logic             O_DONE,
   output logic             O_SYNC_OK,
   output logic [31:0]      O_CLIENT_DELAY
);
   cse_if lnk ();

   cse_delay_calc u_calc (
      .i_clk (I_CLK),
      .i_rst (I_RST),
      .i_ce  (I_CE),
      .lnk   (lnk.calc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Tick pin synchroniser and edge detect
   logic [2:0] tick_sync_reg;
   logic [2:0] tick_sync_next;

   always_comb begin
      tick_sync_next = {tick_sync_reg[1:0], I_TICK};
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         tick_sync_reg <= 3'h0;
      end else if (I_CE) begin
         tick_sync_reg <= tick_sync_next;
      end
   end

   logic tick_pulse;
   assign tick_pulse = tick_sync_reg[1] & ~tick_sync_reg[2];

   ////////////////////////////////////////////////////////////////////////////////
   // Interval counter: event once the reported interval has elapsed
   logic [47:0] ival_reg;
   logic [47:0] ival_next;
   logic [47:0] ival_limit;
   logic        sync_event;
   cse_pkg::cse_state_t state_reg;
   cse_pkg::cse_state_t state_next;

   assign ival_limit = 48'(I_SYNC_COUNT) * 48'(TICKS_PER_UNIT);
   assign sync_event = I_ENABLE && (I_SYNC_COUNT != 16'h0) && (ival_reg >= ival_limit)
                       && (state_reg == cse_pkg::ST_IDLE);

   always_comb begin
      if (!I_ENABLE || sync_event) begin
         ival_next = 48'h0;
      end else if (tick_pulse && ival_reg < ival_limit) begin
         ival_next = ival_reg + 48'h1;
      end else begin
         ival_next = ival_reg;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         ival_reg <= 48'h0;
      end else if (I_CE) begin
         ival_reg <= ival_next;
      end
   end

   // Ticks since the last event, counted apart from the interval counter
   logic [47:0] gap_reg;
   logic [47:0] gap_next;

   always_comb begin
      if (sync_event) begin
         gap_next = 48'h0;
      end else if (tick_pulse && (gap_reg != 48'hffffffffffff)) begin
         gap_next = gap_reg + 48'h1;
      end else begin
         gap_next = gap_reg;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         gap_reg <= 48'h0;
      end else if (I_CE) begin
         gap_reg <= gap_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Exchange state machine and transmit/receive registers
   logic        tx_valid_reg, tx_valid_next;
   logic [31:0] tx_data_reg, tx_data_next;
   logic        tx_last_reg, tx_last_next;
   logic [23:0] sid_reg, sid_next;
   logic [23:0] did_reg, did_next;
   logic [15:0] oxid_reg, oxid_next;
   logic        wka_reg, wka_next;
   logic        done_reg, done_next;
   logic        ok_reg, ok_next;
   logic [31:0] cdly_reg, cdly_next;
   logic [31:0] tmo_reg, tmo_next;
   logic        rx_hit;
   logic        tx_take;

   assign rx_hit  = I_RX_VALID && (I_RX_OXID == oxid_reg);
   assign tx_take = tx_valid_reg && I_TX_READY;
   assign lnk.tick_pulse = tick_pulse;
   assign lnk.evt_latch  = sync_event;
   assign lnk.tx_latch   = (state_reg == cse_pkg::ST_DEFER) && !I_TX_BUSY;
   assign lnk.prop_delay = I_PROP_DELAY;

   always_comb begin
      state_next    = state_reg;
      tx_valid_next = tx_valid_reg;
      tx_data_next  = tx_data_reg;
      tx_last_next  = tx_last_reg;
      sid_next      = sid_reg;
      did_next      = did_reg;
      oxid_next     = oxid_reg;
      wka_next      = wka_reg;
      done_next     = 1'b0;
      ok_next       = ok_reg;
      cdly_next     = cdly_reg;
      tmo_next      = tmo_reg;
      unique case (state_reg)
         cse_pkg::ST_IDLE: begin
            if (sync_event) begin
               oxid_next  = oxid_reg + 16'h1;
               wka_next   = I_USE_WKA;
               sid_next   = I_USE_WKA ? cse_pkg::WKA_ID : I_SERVER_ID;
               did_next   = I_CLIENT_ID;
               state_next = cse_pkg::ST_DEFER;
            end
         end
         cse_pkg::ST_DEFER: begin
            if (!I_TX_BUSY) begin
               tx_valid_next = 1'b1;
               tx_data_next  = cse_pkg::SC_CMD;
               tx_last_next  = 1'b0;
               state_next    = cse_pkg::ST_CMD;
            end
         end
         cse_pkg::ST_CMD: begin
            if (tx_take) begin
               tx_data_next = lnk.server_delay;
               tx_last_next = 1'b1;
               state_next   = cse_pkg::ST_DLY;
            end
         end
         cse_pkg::ST_DLY: begin
            if (tx_take) begin
               tx_valid_next = 1'b0;
               tx_last_next  = 1'b0;
               tmo_next      = 32'h0;
               state_next    = cse_pkg::ST_ACC;
            end
         end
         cse_pkg::ST_ACC, cse_pkg::ST_CDLY: begin
            tmo_next = tmo_reg + 32'h1;
            if (rx_hit && (I_RX_REJECT || (state_reg == cse_pkg::ST_ACC
                                           && I_RX_DATA != cse_pkg::SC_ACC))) begin
               ok_next    = 1'b0;
               done_next  = 1'b1;
               state_next = cse_pkg::ST_IDLE;
            end else if (rx_hit && state_reg == cse_pkg::ST_ACC) begin
               state_next = cse_pkg::ST_CDLY;
            end else if (rx_hit) begin
               cdly_next  = I_RX_DATA;
               ok_next    = 1'b1;
               done_next  = 1'b1;
               state_next = cse_pkg::ST_IDLE;
            end else if (tmo_reg >= 32'(TIMEOUT_CYC - 1)) begin
               ok_next    = 1'b0;
               done_next  = 1'b1;
               state_next = cse_pkg::ST_IDLE;
            end
         end
         default: begin
            tx_valid_next = 1'b0;
            state_next    = cse_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         state_reg    <= cse_pkg::ST_IDLE;
         tx_valid_reg <= 1'b0;
         tx_data_reg  <= cse_pkg::WORD_RESET;
         tx_last_reg  <= 1'b0;
         sid_reg      <= 24'h0;
         did_reg      <= 24'h0;
         oxid_reg     <= cse_pkg::OXID_RESET;
         wka_reg      <= 1'b0;
         done_reg     <= 1'b0;
         ok_reg       <= 1'b0;
         cdly_reg     <= cse_pkg::WORD_RESET;
         tmo_reg      <= 32'h0;
      end else if (I_CE) begin
         state_reg    <= state_next;
         tx_valid_reg <= tx_valid_next;
         tx_data_reg  <= tx_data_next;
         tx_last_reg  <= tx_last_next;
         sid_reg      <= sid_next;
         did_reg      <= did_next;
         oxid_reg     <= oxid_next;
         wka_reg      <= wka_next;
         done_reg     <= done_next;
         ok_reg       <= ok_next;
         cdly_reg     <= cdly_next;
         tmo_reg      <= tmo_next;
      end
   end

   // Outputs straight from flip-flops; sequence initiative passed with the last word
   logic busy_reg;
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         busy_reg <= 1'b0;
      end else if (I_CE) begin
         busy_reg <= (state_next != cse_pkg::ST_IDLE);
      end
   end

   assign O_TX_VALID     = tx_valid_reg;
   assign O_TX_DATA      = tx_data_reg;
   assign O_TX_LAST      = tx_last_reg;
   assign O_TX_SID       = sid_reg;
   assign O_TX_DID       = did_reg;
   assign O_TX_OXID      = oxid_reg;
   assign O_TX_SEQ_INIT  = tx_last_reg;
   assign O_BUSY         = busy_reg;
   assign O_DONE         = done_reg;
   assign O_SYNC_OK      = ok_reg;
   assign O_CLIENT_DELAY = cdly_reg;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   wka_sid_a: assert property (O_TX_VALID && wka_reg |-> O_TX_SID == cse_pkg::WKA_ID)
      else $error("well-known source id not used");
   dest_id_a: assert property ((I_CE && sync_event) |=> O_TX_DID == $past(I_CLIENT_ID))
      else $error("destination id is not the client");
   one_req_a: assert property ((state_reg == cse_pkg::ST_ACC) |-> !O_TX_VALID)
      else $error("second request while awaiting reply");
   ival_gap_a: assert property (sync_event |-> gap_reg >= ival_limit && ival_limit != 0)
      else $error("request issued before interval elapsed");
   cmd_word_a: assert property ((I_CE && state_reg == cse_pkg::ST_DEFER && !I_TX_BUSY)
      |=> O_TX_VALID && O_TX_DATA == cse_pkg::SC_CMD && !O_TX_LAST)
      else $error("request command word wrong");
   delay_word_a: assert property ((I_CE && state_reg == cse_pkg::ST_CMD && tx_take)
      |=> O_TX_LAST && O_TX_DATA == $past(lnk.server_delay))
      else $error("server delay word wrong");
   reject_none_a: assert property ((I_CE && state_reg == cse_pkg::ST_ACC && rx_hit
      && I_RX_REJECT) |=> O_DONE && !O_SYNC_OK)
      else $error("reject not reported as failure");
   defer_a: assert property ((I_CE && state_reg == cse_pkg::ST_DEFER && I_TX_BUSY)
      |=> state_reg == cse_pkg::ST_DEFER && !O_TX_VALID)
      else $error("request sent during a busy frame");

   ok_done_c:    cover property (O_DONE && O_SYNC_OK);
   reject_c:     cover property (O_DONE && !O_SYNC_OK);
   deferred_c:   cover property (state_reg == cse_pkg::ST_DEFER && I_TX_BUSY
                                 ##1 !I_TX_BUSY ##1 O_TX_VALID);
endmodule

// File: rtl/cse_pkg.sv
// Constants for the clock synchronize request/accept exchange, server end
// Overview of operation
// - Server originates; well-known source id FFFF6
// - Destination id is the synchronized client
// - One request, one reply, same exchange
// - Requests never faster than reported interval
// - Request payload: 03000000 then server delay
// - Server delay: event-to-send ticks plus propagation
// - Reject reply means no synchronization info
// - Interval count is ticks in millions
// - Defer symbols while a frame is sending
package cse_pkg;
   localparam logic [23:0] WKA_ID           = 24'h0ffff6;
   localparam logic [31:0] SC_CMD           = 32'h03000000;
   localparam logic [31:0] SC_ACC           = 32'h04000000;
   localparam int          TICKS_PER_UNIT   = 1000000;
   localparam int          CLK_MHZ          = 40;
   localparam int          REPLY_TIMEOUT_US = 1000;
   localparam int          REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_US * CLK_MHZ;
   localparam logic [15:0] OXID_RESET       = 16'h0000;
   localparam logic [31:0] WORD_RESET       = 32'h00000000;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DEFER = 3'b001,
      ST_CMD   = 3'b010,
      ST_DLY   = 3'b011,
      ST_ACC   = 3'b100,
      ST_CDLY  = 3'b101
   } cse_state_t;
endpackage

// File: rtl/cse_if.sv
// Carrier between the exchange controller and the tick/delay calculator
`timescale 1ns/1ps
interface cse_if;
   logic        tick_pulse;
   logic        evt_latch;
   logic        tx_latch;
   logic [31:0] prop_delay;
   logic [31:0] server_delay;

   modport calc (input tick_pulse, input evt_latch, input tx_latch, input prop_delay,
                 output server_delay);
   modport ctrl (output tick_pulse, output evt_latch, output tx_latch, output prop_delay,
                 input server_delay);
endinterface

// File: rtl/cse_delay_calc.sv
// Free-running tick counter with event and send snapshots
`timescale 1ns/1ps
module cse_delay_calc (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   cse_if.calc       lnk
);
   logic [31:0] tick_reg;
   logic [31:0] tick_next;
   logic [31:0] evt_reg;
   logic [31:0] evt_next;
   logic [31:0] tx_reg;
   logic [31:0] tx_next;

   // Counter and snapshots
   always_comb begin
      tick_next = tick_reg + {31'h0, lnk.tick_pulse};
      evt_next  = lnk.evt_latch ? tick_reg : evt_reg;
      tx_next   = lnk.tx_latch ? tick_reg : tx_reg;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tick_reg <= 32'h0;
         evt_reg  <= 32'h0;
         tx_reg   <= 32'h0;
      end else if (i_ce) begin
         tick_reg <= tick_next;
         evt_reg  <= evt_next;
         tx_reg   <= tx_next;
      end
   end

   // Unsigned wrapping sum of wait time and propagation
   assign lnk.server_delay = (tx_reg - evt_reg) + lnk.prop_delay;

   ////////////////////////////////////////////////////////////////////////////////
   snap_tx_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_ce && lnk.tx_latch) |=> (tx_reg == $past(tick_reg)))
      else $error("send snapshot missed tick count");
endmodule

// File: test/cse_client_model.sv
// Client port model: takes the two-word request and replies on the same exchange in modes 0, 1 and 3, not in mode 2
`timescale 1ns/1ps
module cse_client_model #(
   parameter logic [7:0] RSN_UNABLE = 8'h09,  // Unable-to-perform reason, plain value
   parameter logic [7:0] EXPL_CAUSE = 8'h01   // Explanation of the cause, plain value
) (
   input  wire logic        i_clk,
   input  wire logic [1:0]  i_mode,
   input  wire logic [3:0]  i_slow,
   input  wire logic [7:0]  i_turn,
   input  wire logic        i_tx_valid,
   input  wire logic [31:0] i_tx_data,
   input  wire logic        i_tx_last,
   input  wire logic [15:0] i_tx_oxid,
   input  wire logic        i_tx_seq_init,
   output logic             o_ready,
   output logic             o_rx_valid,
   output logic             o_rx_reject,
   output logic [15:0]      o_rx_oxid,
   output logic [31:0]      o_rx_data,
   output logic [31:0]      o_cmd_word,
   output logic [31:0]      o_dly_word
);
   logic [15:0] xid;
   logic        si;

   // Sends n reply words on the request's exchange, then scrambles the idle lines
   task automatic reply(input logic rej, input int n, input logic [31:0] w0,
                        input logic [31:0] w1);
      for (int k = 0; k < n; k++) begin
         #1;
         o_rx_valid = 1'b1;
         o_rx_reject = rej;
         o_rx_oxid = xid;
         o_rx_data = (k == 0) ? w0 : w1;
         @(posedge i_clk);
      end
      #1;
      o_rx_valid = 1'b0;
      o_rx_reject = 1'b0;
      o_rx_oxid = ~xid;
      o_rx_data = ~o_rx_data;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Request capture, stall and reply
   initial begin
      o_ready = 1'b0;
      o_rx_valid = 1'b0;
      o_rx_reject = 1'b0;
      o_rx_oxid = 16'h0000;
      o_rx_data = 32'h00000000;
      o_cmd_word = 32'h00000000;
      o_dly_word = 32'h00000000;
      xid = 16'h0000;
      forever begin
         @(posedge i_clk);
         if (i_tx_valid && o_ready && !i_tx_last) begin
            o_cmd_word = i_tx_data;
            xid = i_tx_oxid;
         end else if (i_tx_valid && o_ready) begin
            o_dly_word = i_tx_data;
            si = i_tx_seq_init;                   // Taken with the last word
            #1 o_ready = 1'b0;
            if (!si) continue;
            repeat (i_turn) @(posedge i_clk);
            if (i_mode == 2'd0) begin
               reply(1'b0, 2, cse_pkg::SC_ACC, {24'h000000, i_turn});
            end else if (i_mode == 2'd1) begin
               reply(1'b1, 1, {8'h00, RSN_UNABLE, EXPL_CAUSE, 8'h00}, 32'h0);
            end else if (i_mode == 2'd3) begin
               reply(1'b0, 2, cse_pkg::SC_CMD, {24'h000000, i_turn});
            end
         end else if (i_tx_valid) begin
            repeat (i_slow) @(posedge i_clk);
            #1 o_ready = 1'b1;
         end
      end
   end
endmodule

// File: test/clock_sync_els_exchange_tb.sv
// Self-checking bench for the server end of the clock synchronize exchange
`timescale 1ns/1ps
module clock_sync_els_exchange_tb;
   localparam logic [31:0] PROP   = 32'h00000025;
   localparam logic [23:0] CLIENT = 24'h0a0b0c;
   localparam logic [23:0] SERVER = 24'h010203;
   localparam int          TPU    = 2;
   logic        clk, rst, ce, en, use_wka, tick, tx_busy, ready, rx_valid, rx_reject;
   logic        tx_valid, tx_last, seq_init, busy, done, sync_ok;
   logic [1:0]  mode;
   logic [3:0]  slow;
   logic [7:0]  turn;
   logic [15:0] rx_oxid, oxid, cnt;
   logic [23:0] tx_sid, tx_did;
   logic [31:0] rx_data, tx_data, cdly, cmd_w, dly_w;
   int          err_count, compares;

   cse_server #(.TIMEOUT_CYC(50), .TICKS_PER_UNIT(TPU)) cse_server_inst (
      .I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_ENABLE(en), .I_SYNC_COUNT(cnt),
      .I_CLIENT_ID(CLIENT), .I_SERVER_ID(SERVER), .I_USE_WKA(use_wka),
      .I_PROP_DELAY(PROP), .I_TICK(tick), .I_TX_BUSY(tx_busy), .I_TX_READY(ready),
      .I_RX_VALID(rx_valid), .I_RX_OXID(rx_oxid), .I_RX_REJECT(rx_reject),
      .I_RX_DATA(rx_data), .O_TX_VALID(tx_valid), .O_TX_DATA(tx_data),
      .O_TX_LAST(tx_last), .O_TX_SID(tx_sid), .O_TX_DID(tx_did), .O_TX_OXID(oxid),
      .O_TX_SEQ_INIT(seq_init), .O_BUSY(busy), .O_DONE(done), .O_SYNC_OK(sync_ok),
      .O_CLIENT_DELAY(cdly));

   cse_client_model cse_client_model_inst (
      .i_clk(clk), .i_mode(mode), .i_slow(slow), .i_turn(turn), .i_tx_valid(tx_valid),
      .i_tx_data(tx_data), .i_tx_last(tx_last), .i_tx_oxid(oxid),
      .i_tx_seq_init(seq_init), .o_ready(ready), .o_rx_valid(rx_valid),
      .o_rx_reject(rx_reject), .o_rx_oxid(rx_oxid), .o_rx_data(rx_data),
      .o_cmd_word(cmd_w), .o_dly_word(dly_w));

   ////////////////////////////////////////////////////////////////////////////////
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Compares one value and counts a mismatch
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then ends the run
   task automatic report_and_stop();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Bounded wait for busy or for the done pulse
   task automatic wait_out(input bit want_done, input int lim);
      int n;
      n = 0;
      while ((want_done ? done : busy) !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            err_count++;
            $display("[ERR] wait expected 1 seen 0");
            report_and_stop();
         end
      end
   endtask

   // Sync clock ticks on the pin, then time for the synchronizer to settle
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clk);
         tick = 1'b1;
         repeat (2) @(negedge clk);
         tick = 1'b0;
         @(negedge clk);
      end
      repeat (5) @(negedge clk);
   endtask

   // One exchange: interval, ids, deferral, request words, reply outcome
   task automatic exchange(input logic [1:0] m, input int hold, input logic [23:0] sid,
                           input logic ok, input logic [31:0] cd);
      logic [15:0] xid;
      xid = oxid;
      mode = m;
      en = 1'b1;
      tx_busy = (hold > 0);
      ticks(TPU * cnt - 1);
      chk("early event", 32'h0, {31'h0, busy});
      ticks(1);
      wait_out(1'b0, 20);
      chk("source id", {8'h0, sid}, {8'h0, tx_sid});
      chk("dest id", {8'h0, CLIENT}, {8'h0, tx_did});
      chk("exchange id", {16'h0, xid + 16'h0001}, {16'h0, oxid});
      if (hold > 0) begin
         ticks(hold);
         chk("deferred", 32'h0, {31'h0, tx_valid});
      end
      tx_busy = 1'b0;
      wait_out(1'b1, 200);
      chk("sync ok", {31'h0, ok}, {31'h0, sync_ok});
      chk("client delay", cd, cdly);
      chk("command word", cse_pkg::SC_CMD, cmd_w);
      chk("server delay", PROP + hold, dly_w);
      @(negedge clk);
      en = 1'b0;
      @(negedge clk);
   endtask

   // Zero interval count never starts an exchange; low clock enable freezes the counter
   task automatic quiet();
      cnt = 16'h0000;
      en = 1'b1;
      ticks(5);
      chk("zero count event", 32'h0, {31'h0, busy});
      cnt = 16'h0002;
      ce = 1'b0;
      ticks(5);
      chk("frozen event", 32'h0, {31'h0, busy});
      ce = 1'b1;
      en = 1'b0;
      @(negedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      cnt = 16'h0002;
      en = 1'b0;
      use_wka = 1'b1;
      tick = 1'b0;
      tx_busy = 1'b0;
      mode = 2'd0;
      slow = 4'h0;
      turn = 8'h06;
      err_count = 0;
      compares = 0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("reset outputs", 32'h0, {26'h0, tx_valid, tx_last, seq_init, busy, done, sync_ok});
      quiet();
      exchange(2'd0, 0, cse_pkg::WKA_ID, 1'b1, 32'h00000006);
      slow = 4'h3;
      use_wka = 1'b0;
      turn = 8'h09;
      exchange(2'd0, 3, SERVER, 1'b1, 32'h00000009);
      cnt = 16'h0001;
      exchange(2'd1, 0, SERVER, 1'b0, 32'h00000009);
      exchange(2'd2, 0, SERVER, 1'b0, 32'h00000009);
      exchange(2'd3, 0, SERVER, 1'b0, 32'h00000009);
      report_and_stop();
   end
endmodule
